/* File: sac_top.sv */
// Converter control and accumulator: APB registers, start-source
// selection, dc-dc sync hold-off, conversion sequencing, 16-bit
// accumulation, formatting and window compare.
// Assumes all inputs synchronous to pclk and sample_code stable at the
// last conversion clock tick of each conversion.
//
// Function
// - Single samples right or left justified
// - Unused result bits read as zero
// - Sum stored only after final conversion
// - Repeat count 1, 4, 8, 16, 32, 64
// - 16-bit accumulator, optional shift 1-3
// - Conversion clock from divided system or oscillator
// - Five selectable start sources
// - Busy high during conversion, low after
// - Busy falling at series end sets done flag
// - Timer byte overflow chosen by mode
// - Sync mode holds start until dc-dc sync
// - Sync mode clocks from dc-dc clock
// - Invert bit inverts dc-dc conversion clock
// - Done only after full repeat count
// - Burst runs series from one trigger
// - Window compare only after full series
`timescale 1ns/1ps
module sac_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer0_ovf,
  input  wire logic        timer2_low_ovf,
  input  wire logic        timer2_high_ovf,
  input  wire logic        timer2_split,
  input  wire logic        timer3_low_ovf,
  input  wire logic        timer3_high_ovf,
  input  wire logic        timer3_split,
  input  wire logic        external_start_input,
  input  wire logic        lpo_tick,
  input  wire logic        dcdc_clk,
  input  wire logic        dcdc_sync,
  input  wire logic [9:0]  sample_code,
  output logic             conversion_busy,
  output logic             conversion_done,
  output logic             window_flag,
  output logic      [7:0]  result_high_byte,
  output logic      [7:0]  result_low_byte
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        en_q;
  logic [2:0]  src_q;
  logic        done_q;
  logic        win_q;
  logic [4:0]  div_q;
  logic        burst_q;
  logic [2:0]  sjst_q;
  logic [2:0]  rpt_q;
  logic        sync_q;
  logic        inv_q;
  logic [15:0] gt_q;
  logic [15:0] lt_q;
  logic [15:0] result_q;
  logic [31:0] prdata_q;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  sac_pkg::sac_state_t state_q;
  sac_pkg::sac_state_t state_d;
  logic        busy_q;
  logic        ext_q;
  logic [3:0]  tick_q;
  logic [7:0]  wait_q;
  logic [6:0]  count_q;
  logic [15:0] acc_q;

  // ----------------------------------------------------------------
  // Combinational nets
  // ----------------------------------------------------------------
  logic        setup_ph;
  logic        access_ph;
  logic        wr_en;
  logic        hit_ctrl;
  logic        hit_cfg;
  logic        hit_acc;
  logic        hit_dcdc;
  logic        hit_data;
  logic        hit_win;
  logic        addr_hit;
  logic        wr_ctrl;
  logic        wr_cfg;
  logic        wr_acc;
  logic        wr_dcdc;
  logic        wr_win;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_word;
  logic [2:0]  wr_src;
  logic        soft_start;
  logic        ext_rise;
  logic        t2_ovf;
  logic        t3_ovf;
  logic        sel_trig;
  logic        trig;
  logic        conv_tick;
  logic        conv_end;
  logic [6:0]  count_inc;
  logic [6:0]  series_len;
  logic        series_last;
  logic [15:0] acc_base;
  logic [15:0] acc_sum;
  logic [15:0] fmt_word;
  logic        win_hit;
  logic        sync_done;
  logic        done_clr;
  logic        win_clr;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero wait states: read data is captured in the setup cycle
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en     = access_ph & pwrite;
  assign hit_ctrl  = (paddr == sac_pkg::ADDR_CTRL);
  assign hit_cfg   = (paddr == sac_pkg::ADDR_CFG);
  assign hit_acc   = (paddr == sac_pkg::ADDR_ACC);
  assign hit_dcdc  = (paddr == sac_pkg::ADDR_DCDC);
  assign hit_data  = (paddr == sac_pkg::ADDR_DATA);
  assign hit_win   = (paddr == sac_pkg::ADDR_WIN);
  assign addr_hit  = hit_ctrl | hit_cfg | hit_acc | hit_dcdc | hit_data | hit_win;
  assign wr_ctrl   = wr_en & hit_ctrl;
  assign wr_cfg    = wr_en & hit_cfg;
  assign wr_acc    = wr_en & hit_acc;
  assign wr_dcdc   = wr_en & hit_dcdc;
  assign wr_win    = wr_en & hit_win;
  assign pready    = 1'b1;
  assign pslverr   = access_ph & ~addr_hit;

  // Read words; unlisted bits read as zero
  assign rd_ctrl = {25'h0000000, src_q, win_q, done_q, busy_q, en_q};
  assign rd_word = hit_ctrl ? rd_ctrl :
                   hit_cfg  ? {23'h000000, burst_q, 3'h0, div_q} :
                   hit_acc  ? {26'h0000000, rpt_q, sjst_q} :
                   hit_dcdc ? {30'h00000000, inv_q, sync_q} :
                   hit_data ? {16'h0000, result_q} :
                   hit_win  ? {lt_q, gt_q} : 32'h00000000;
  assign prdata  = prdata_q;

  // ----------------------------------------------------------------
  // Start sources
  // ----------------------------------------------------------------
  assign wr_src     = pwdata[sac_pkg::CTRL_SRC_LSB +: sac_pkg::SRC_W];
  // Software start uses the source written in the same access
  assign soft_start = wr_ctrl & pwdata[sac_pkg::CTRL_BUSY_BIT]
                      & (wr_src == sac_pkg::SRC_SOFT);
  assign ext_rise   = external_start_input & ~ext_q;
  assign t2_ovf     = timer2_split ? timer2_low_ovf : timer2_high_ovf;
  assign t3_ovf     = timer3_split ? timer3_low_ovf : timer3_high_ovf;
  // Only the selected source passes; the rest are dropped
  assign sel_trig   = (src_q == sac_pkg::SRC_SOFT) ? soft_start :
                      (src_q == sac_pkg::SRC_TMR0) ? timer0_ovf :
                      (src_q == sac_pkg::SRC_TMR2) ? t2_ovf :
                      (src_q == sac_pkg::SRC_TMR3) ? t3_ovf :
                      (src_q == sac_pkg::SRC_EXT)  ? ext_rise : 1'b0;
  // Triggers during a conversion are lost, not queued
  assign trig       = en_q & sel_trig & (state_q == sac_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  sac_conv_clock u_conv_clock (
    .pclk       (pclk),
    .presetn    (presetn),
    .burst_en   (burst_q),
    .sync_en    (sync_q),
    .clk_invert (inv_q),
    .divider    (div_q),
    .lpo_tick   (lpo_tick),
    .dcdc_clk   (dcdc_clk),
    .conv_tick  (conv_tick)
  );

  // ----------------------------------------------------------------
  // Series bookkeeping
  // ----------------------------------------------------------------
  assign conv_end    = (state_q == sac_pkg::ST_CONVERT) & conv_tick
                       & (tick_q == sac_pkg::CONV_LAST);
  assign count_inc   = count_q + 7'h01;
  assign series_len  = sac_pkg::sac_repeat_len(rpt_q);
  // Greater-or-equal so a count shrunk mid-series still ends it
  assign series_last = conv_end & (count_inc >= series_len);
  assign acc_base    = (count_q == 7'h00) ? 16'h0000 : acc_q;
  assign acc_sum     = acc_base + {6'h00, sample_code};
  // Sync watchdog bounds the hold-off to one slowest dc-dc period
  assign sync_done   = dcdc_sync | (wait_q == sac_pkg::SYNC_LAST);

  sac_format u_format (
    .acc_word (acc_sum),
    .sjst     (sjst_q),
    .fmt_word (fmt_word)
  );

  assign win_hit  = (fmt_word > gt_q) | (fmt_word < lt_q);
  assign done_clr = wr_ctrl & ~pwdata[sac_pkg::CTRL_DONE_BIT];
  assign win_clr  = wr_ctrl & ~pwdata[sac_pkg::CTRL_WIN_BIT];

  // Next state of the conversion sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      sac_pkg::ST_IDLE:
        if (trig)
          state_d = sync_q ? sac_pkg::ST_WAIT_SYNC
                           : sac_pkg::ST_CONVERT;
      sac_pkg::ST_WAIT_SYNC:
        if (sync_done)
          state_d = sac_pkg::ST_CONVERT;
      sac_pkg::ST_CONVERT:
        if (conv_end)
          // Burst chains the series without further triggers
          state_d = (burst_q & ~series_last) ? sac_pkg::ST_CONVERT
                                             : sac_pkg::ST_IDLE;
      // The fourth code of the two-bit state is unused; recover to idle
      default:
        state_d = sac_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q    <= 1'b0;
      src_q   <= sac_pkg::SRC_SOFT;
      div_q   <= 5'h00;
      burst_q <= 1'b0;
      sjst_q  <= 3'h0;
      rpt_q   <= 3'h0;
      sync_q  <= 1'b0;
      inv_q   <= 1'b0;
      gt_q    <= sac_pkg::GT_RST;
      lt_q    <= sac_pkg::LT_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        en_q  <= pwdata[sac_pkg::CTRL_EN_BIT];
        src_q <= wr_src;
      end
      if (wr_cfg)
      begin
        div_q   <= pwdata[sac_pkg::CFG_DIV_LSB +: sac_pkg::DIV_W];
        burst_q <= pwdata[sac_pkg::CFG_BURST_BIT];
      end
      if (wr_acc)
      begin
        sjst_q <= pwdata[sac_pkg::ACC_SJST_LSB +: sac_pkg::SJST_W];
        rpt_q  <= pwdata[sac_pkg::ACC_RPT_LSB +: sac_pkg::RPT_W];
      end
      if (wr_dcdc)
      begin
        sync_q <= pwdata[sac_pkg::DCDC_SYNC_BIT];
        inv_q  <= pwdata[sac_pkg::DCDC_INV_BIT];
      end
      if (wr_win)
      begin
        gt_q <= pwdata[sac_pkg::WIN_GT_LSB +: sac_pkg::WORD_W];
        lt_q <= pwdata[sac_pkg::WIN_LT_LSB +: sac_pkg::WORD_W];
      end
    end
  end

  // Status flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q   <= 1'b0;
      win_q    <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      done_q <= series_last | (done_q & ~done_clr);
      win_q  <= (series_last & win_hit) | (win_q & ~win_clr);
      if (setup_ph & ~pwrite)
        prdata_q <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= sac_pkg::ST_IDLE;
      busy_q  <= 1'b0;
      ext_q   <= 1'b0;
      tick_q  <= 4'h0;
      wait_q  <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      busy_q  <= (state_d != sac_pkg::ST_IDLE);
      ext_q   <= external_start_input;
      if (state_q != sac_pkg::ST_CONVERT || conv_end)
        tick_q <= 4'h0;
      else if (conv_tick)
        tick_q <= tick_q + 4'h1;
      if (state_q != sac_pkg::ST_WAIT_SYNC)
        wait_q <= 8'h00;
      else
        wait_q <= wait_q + 8'h01;
    end
  end

  // Accumulator and presented result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q  <= 7'h00;
      acc_q    <= 16'h0000;
      result_q <= 16'h0000;
    end
    else
    begin
      if (conv_end)
      begin
        count_q <= series_last ? 7'h00 : count_inc;
        acc_q   <= acc_sum;
      end
      // Data moves only at series end so reads never see a partial sum
      if (series_last)
        result_q <= fmt_word;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign conversion_busy  = busy_q;
  assign conversion_done  = done_q;
  assign window_flag      = win_q;
  assign result_high_byte = result_q[15:8];
  assign result_low_byte  = result_q[7:0];

endmodule

/* File: sac_pkg.sv */
// Package of the converter control and accumulator block: register map,
// field positions, encodings, reset values and timing counts.
// Assumes a 200 MHz APB clock and 32-bit APB data.
package sac_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG  = 8'h04;
  localparam logic [7:0] ADDR_ACC  = 8'h08;
  localparam logic [7:0] ADDR_DCDC = 8'h0c;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_WIN  = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_BUSY_BIT = 1;
  localparam int CTRL_DONE_BIT = 2;
  localparam int CTRL_WIN_BIT  = 3;
  localparam int CTRL_SRC_LSB  = 4;
  localparam int SRC_W         = 3;
  localparam int CFG_DIV_LSB   = 0;
  localparam int DIV_W         = 5;
  localparam int CFG_BURST_BIT = 8;
  localparam int ACC_SJST_LSB  = 0;
  localparam int SJST_W        = 3;
  localparam int ACC_RPT_LSB   = 3;
  localparam int RPT_W         = 3;
  localparam int DCDC_SYNC_BIT = 0;
  localparam int DCDC_INV_BIT  = 1;
  localparam int WIN_GT_LSB    = 0;
  localparam int WIN_LT_LSB    = 16;
  localparam int WORD_W        = 16;
  localparam int SAR_BITS      = 10;
  localparam int LEFT_PAD      = WORD_W - SAR_BITS;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_SOFT = 3'h0;
  localparam logic [2:0] SRC_TMR0 = 3'h1;
  localparam logic [2:0] SRC_TMR2 = 3'h2;
  localparam logic [2:0] SRC_TMR3 = 3'h3;
  localparam logic [2:0] SRC_EXT  = 3'h4;
  localparam int         SJST_LEFT_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] GT_RST = 16'hffff;
  localparam logic [15:0] LT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SYNC_MAX_NS   = 625;
  localparam int SYNC_MAX_CYC  = (SYNC_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [7:0] SYNC_LAST = 8'(SYNC_MAX_CYC - 1);
  localparam int CONV_TICKS    = SAR_BITS + 1;
  localparam logic [3:0] CONV_LAST = 4'(CONV_TICKS - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_SYNC, ST_CONVERT} sac_state_t;

  // Number of samples per series for a repeat-count code
  function automatic logic [6:0] sac_repeat_len(input logic [2:0] code);
    logic [6:0] len;
    len = 7'h01;
    unique case (code)
      3'h1:    len = 7'h04;
      3'h2:    len = 7'h08;
      3'h3:    len = 7'h10;
      3'h4:    len = 7'h20;
      3'h5:    len = 7'h40;
      default: len = 7'h01;
    endcase
    return len;
  endfunction

endpackage

/* File: sac_conv_clock.sv */
// Conversion clock tick generator.
// Assumes lpo_tick and dcdc_clk are synchronous to pclk.
`timescale 1ns/1ps
module sac_conv_clock (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       burst_en,
  input  wire logic       sync_en,
  input  wire logic       clk_invert,
  input  wire logic [4:0] divider,
  input  wire logic       lpo_tick,
  input  wire logic       dcdc_clk,
  output logic            conv_tick
);

  logic       dcdc_q;
  logic [4:0] div_q;
  logic       tick_q;
  logic       dcdc_lvl;
  logic       dcdc_rise;
  logic       src_tick;
  logic       wrap;

  // ------------------------------------------------------------
  // Source selection
  // ------------------------------------------------------------
  assign dcdc_lvl  = dcdc_clk ^ clk_invert;
  assign dcdc_rise = dcdc_lvl & ~dcdc_q;
  // Dc-dc clock wins over burst so conversions line up with switching
  assign src_tick  = sync_en ? dcdc_rise :
                     (burst_en ? lpo_tick : 1'b1);
  // Greater-or-equal so a shrunk divisor cannot strand the counter
  assign wrap      = (div_q >= divider);

  // Divider counter and registered tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dcdc_q <= 1'b0;
      div_q  <= 5'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      dcdc_q <= dcdc_lvl;
      tick_q <= src_tick & wrap;
      if (src_tick)
        div_q <= wrap ? 5'h00 : div_q + 5'h01;
    end
  end

  assign conv_tick = tick_q;

endmodule

/* File: sac_format.sv */
// Result formatter: justification and right shift of the accumulator.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module sac_format (
  input  wire logic [15:0] acc_word,
  input  wire logic [2:0]  sjst,
  output logic      [15:0] fmt_word
);

  logic [15:0] left_word;
  logic [15:0] right_word;

  // ------------------------------------------------------------
  // Format selection
  // ------------------------------------------------------------
  // Left form keeps only the 10-bit code; zeros fill the low bits
  assign left_word  = {acc_word[sac_pkg::SAR_BITS-1:0],
                       {sac_pkg::LEFT_PAD{1'b0}}};
  // Logical shift brings zeros in at the top
  assign right_word = acc_word >> sjst[1:0];
  // Left form is only meaningful for single samples
  assign fmt_word   = sjst[sac_pkg::SJST_LEFT_BIT] ? left_word
                                                   : right_word;

endmodule

/* File: sac_assertions.sv */
// Port checker of the converter control block.
// Bound to sac_top from the testbench top file; one clock domain.
`timescale 1ns/1ps
module sac_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer0_ovf,
  input wire logic        timer2_low_ovf,
  input wire logic        timer2_high_ovf,
  input wire logic        timer3_low_ovf,
  input wire logic        timer3_high_ovf,
  input wire logic        external_start_input,
  input wire logic        conversion_busy,
  input wire logic        conversion_done,
  input wire logic        window_flag,
  input wire logic [7:0]  result_high_byte,
  input wire logic [7:0]  result_low_byte
);
  // ----------------------------------------------------------------
  // Helpers: any trigger is loose on purpose, selection is tested
  // ----------------------------------------------------------------
  logic       ext_q;
  wire        unmapped = (paddr[1:0] != 2'h0) || (paddr > 8'h14);
  wire [15:0] res      = {result_high_byte, result_low_byte};
  wire        trig     = (psel && penable && pwrite) || timer0_ovf || timer2_low_ovf || timer2_high_ovf
                         || timer3_low_ovf || timer3_high_ovf || (external_start_input && !ext_q);
  // Start pin one cycle back
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ext_q <= 1'b0;
    else
      ext_q <= external_start_input;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd_data; psel && !penable && !pwrite && paddr == sac_pkg::ADDR_DATA ##1 penable; endsequence
  sequence s_end; $fell(conversion_busy); endsequence
  property p_ready; pready; endproperty
  property p_err; pslverr == (psel && penable && unmapped); endproperty
  property p_err_data; psel && penable && !pwrite && unmapped |-> prdata == 32'h0; endproperty
  property p_busy_cause; $rose(conversion_busy) |-> $past(trig); endproperty
  property p_busy_min; $rose(conversion_busy) |-> conversion_busy [*8]; endproperty
  property p_done; $rose(conversion_done) |-> s_end; endproperty
  property p_win; $rose(window_flag) |-> s_end; endproperty
  property p_res; $changed(res) |-> s_end; endproperty
  property p_rd_data; s_rd_data |-> prdata == {16'h0, $past(res)}; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err: assert property (p_err) else $error("pslverr wrong");
  a_err_data: assert property (p_err_data) else $error("unmapped read data not zero");
  a_busy_cause: assert property (p_busy_cause) else $error("busy rose without trigger");
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  a_done: assert property (p_done) else $error("done rose without busy fall");
  a_win: assert property (p_win) else $error("window flag off series end");
  a_res: assert property (p_res) else $error("result changed mid series");
  a_rd_data: assert property (p_rd_data) else $error("data read mismatch");
endmodule

/* File: sac_partner.sv */
// Far side: timers, start pin, low-power oscillator, dc-dc converter.
// Strobed by the testbench; outputs change on rising pclk edges.
`timescale 1ns/1ps
module sac_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [2:0] which,
  output logic      [5:0] ovf,
  output logic            lpo_tick,
  output logic            dcdc_clk,
  output logic            dcdc_sync
);
  logic [2:0] cnt_q;
  // One pulse per strobe: t0, t2 low, t2 high, t3 low, t3 high, pin
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_q <= 3'h0;
      ovf   <= 6'h0;
    end
    else
    begin
      cnt_q <= cnt_q + 3'h1;
      ovf   <= go ? 6'h1 << which : 6'h0;
    end
  // Oscillator every 4 cycles; one sync per dc-dc period of 8
  assign lpo_tick  = cnt_q[1:0] == 2'h3;
  assign dcdc_clk  = cnt_q[2];
  assign dcdc_sync = cnt_q == 3'h7;
endmodule

/* File: sac_tb.sv */
// Self-checking bench of the converter control block.
// Partner model drives triggers and clocks; checker bound below.
`timescale 1ns/1ps
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, go = 1'b0, err;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        timer2_split = 1'b1, timer3_split = 1'b0;
  logic [7:0]  paddr = 8'h0, result_high_byte, result_low_byte;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0]  which = 3'h0;
  logic [9:0]  sample_code = 10'h0;
  logic [5:0]  ovf;
  logic        pready, pslverr, lpo_tick, dcdc_clk, dcdc_sync;
  logic        conversion_busy, conversion_done, window_flag;
  int          miscompares = 0, n_tests = 0, cyc = 0;
  sac_top sac_top_inst (.*, .timer0_ovf(ovf[0]), .timer2_low_ovf(ovf[1]), .timer2_high_ovf(ovf[2]),
    .timer3_low_ovf(ovf[3]), .timer3_high_ovf(ovf[4]), .external_start_input(ovf[5]));
  sac_partner sac_partner_inst (.*);
  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  always #2.5 pclk = ~pclk;
  // Cuts a hang short
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      give_verdict;
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer; waits for pready, then releases
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Software start, flags cleared; n counts cycles until busy drops
  task conv(output int n);
    // Start is gated by the registered enable, so enable in an earlier write
    apb(1'b1, sac_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, sac_pkg::ADDR_CTRL, 32'h3);
    n = 1;
    while (conversion_busy !== 1'b0)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    logic [31:0] exp [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000ffff};
    for (int i = 0; i < 6; i++)
      rdchk(8'(i * 4), exp[i]);
    apb(1'b0, 8'h18, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b1, sac_pkg::ADDR_DATA, 32'h1234);
    rdchk(sac_pkg::ADDR_DATA, 32'h0);
    $display("reset test done");
  endtask
  task t_format;
    int n;
    sample_code <= 10'h3ff;
    conv(n);
    check(32'(n), 32'd12);
    check(32'(conversion_done), 32'h1);
    check(32'({result_high_byte, result_low_byte}), 32'h03ff);
    rdchk(sac_pkg::ADDR_DATA, 32'h03ff);
    sample_code <= 10'h155;
    apb(1'b1, sac_pkg::ADDR_ACC, 32'h4);
    conv(n);
    rdchk(sac_pkg::ADDR_DATA, 32'h5540);
    sample_code <= 10'h3ff;
    apb(1'b1, sac_pkg::ADDR_CFG, 32'h3);
    conv(n);
    check(32'(n >= 42 && n <= 45), 32'h1);
    rdchk(sac_pkg::ADDR_DATA, 32'hffc0);
    apb(1'b1, sac_pkg::ADDR_CFG, 32'h0);
    $display("format test done");
  endtask
  task t_accum;
    int n;
    apb(1'b1, sac_pkg::ADDR_WIN, 32'h0800);
    apb(1'b1, sac_pkg::ADDR_ACC, 32'h8);
    repeat (3) conv(n);
    check(32'(conversion_done), 32'h0);
    check(32'(window_flag), 32'h0);
    rdchk(sac_pkg::ADDR_DATA, 32'hffc0);
    conv(n);
    check(32'(conversion_done), 32'h1);
    check(32'(window_flag), 32'h1);
    rdchk(sac_pkg::ADDR_DATA, 32'h0ffc);
    sample_code <= 10'h200;
    apb(1'b1, sac_pkg::ADDR_ACC, 32'h9);
    repeat (4) conv(n);
    rdchk(sac_pkg::ADDR_DATA, 32'h0400);
    apb(1'b1, sac_pkg::ADDR_WIN, 32'hffff);
    $display("accumulate test done");
  endtask
  task t_burst;
    int n;
    sample_code <= 10'h3ff;
    apb(1'b1, sac_pkg::ADDR_CFG, 32'h100);
    for (int r = 0; r < 6; r++)
    begin
      apb(1'b1, sac_pkg::ADDR_ACC, 32'(r << 3));
      conv(n);
      check(32'(conversion_done), 32'h1);
      rdchk(sac_pkg::ADDR_DATA, 32'h3ff * (r == 0 ? 1 : 2 << r));
    end
    apb(1'b1, sac_pkg::ADDR_CFG, 32'h0);
    apb(1'b1, sac_pkg::ADDR_ACC, 32'h0);
    $display("burst test done");
  endtask
  task t_sources;
    logic hit;
    for (int s = 1; s < 5; s++)
      for (int k = 0; k < 6; k++)
      begin
        apb(1'b1, sac_pkg::ADDR_CTRL, 32'(s << 4) | 32'h1);
        go <= 1'b1;
        which <= 3'(k);
        @(posedge pclk);
        go <= 1'b0;
        repeat (3) @(posedge pclk);
        hit = (s == 1 && k == 0) || (s == 2 && k == 1) || (s == 3 && k == 4) || (s == 4 && k == 5);
        check(32'(conversion_busy), 32'(hit));
        while (conversion_busy !== 1'b0) @(posedge pclk);
      end
    apb(1'b1, sac_pkg::ADDR_CTRL, 32'h0);
    $display("source test done");
  endtask
  task t_sync;
    int n;
    sample_code <= 10'h2aa;
    apb(1'b1, sac_pkg::ADDR_DCDC, 32'h3);
    conv(n);
    check(32'(n >= 81 && n <= 110), 32'h1);
    rdchk(sac_pkg::ADDR_DATA, 32'h02aa);
    apb(1'b1, sac_pkg::ADDR_DCDC, 32'h0);
    $display("sync test done");
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_format;
    t_accum;
    t_burst;
    t_sources;
    t_sync;
    give_verdict;
  end
endmodule
bind sac_top sac_assertions sac_assertions_inst (.*);
